// File: design/dtf_pkg.sv
package dtf_pkg;

	// ------------------------------------------------------------
	// frame geometry
	// ------------------------------------------------------------
	localparam int DTF_FRAME_BITS = 32;
	localparam int DTF_CMD_BITS = 8;
	localparam int DTF_NCHAN = 16;
	localparam int DTF_CODE_W = 16;
	localparam int DTF_SET_W = 8;
	// data field sits at frame bits [23:8]
	localparam int DTF_DATA_LSB = 8;

	// ------------------------------------------------------------
	// thermal trip points, degrees C (set by the analog detectors)
	// ------------------------------------------------------------
	localparam int DTF_TEMP_TRIP_C = 160;
	localparam int DTF_TEMP_RECOVER_C = 150;

	// ------------------------------------------------------------
	// command codes (upper nibble or whole byte)
	// ------------------------------------------------------------
	localparam logic [3:0] DTF_NIB_WR_CODE = 4'h0;
	localparam logic [3:0] DTF_NIB_WR_SET = 4'h1;
	localparam logic [3:0] DTF_NIB_RD_CODE = 4'h8;
	localparam logic [3:0] DTF_NIB_RD_SET = 4'h9;
	localparam logic [7:0] DTF_CMD_WR_CFG = 8'h70;
	localparam logic [7:0] DTF_CMD_WR_PD = 8'h71;
	localparam logic [7:0] DTF_CMD_WR_FAULT = 8'h76;
	localparam logic [7:0] DTF_CMD_RD_CFG = 8'hF0;
	localparam logic [7:0] DTF_CMD_RD_PD = 8'hF1;
	localparam logic [7:0] DTF_CMD_RD_FAULT = 8'hF6;
	localparam logic [7:0] DTF_CMD_RD_TSD = 8'hF7;

	// ------------------------------------------------------------
	// field positions within the 16-bit data field
	// ------------------------------------------------------------
	localparam int DTF_CFG_RST_BIT = 15;
	localparam int DTF_CFG_TSDOFF_BIT = 2;
	localparam int DTF_CFG_MISC_LSB = 0;
	localparam int DTF_FLT_TSF_BIT = 2;
	// settings byte occupies data bits [11:4] (frame [19:12])
	localparam int DTF_SET_LSB = 4;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [15:0] DTF_CODE_RST = 16'h0000;
	localparam logic [7:0] DTF_SET_RST = 8'h00;
	localparam logic [15:0] DTF_PD_RST = 16'h0000;

endpackage

// File: design/dtf_frame_if.sv
`timescale 1ns/1ns
// frame receiver to command core
interface dtf_frame_if;
	logic cmd_valid;
	logic frame_done;
	logic cs_rise;
	logic [7:0] cmd;
	logic [15:0] data;
	logic [15:0] rd_word;

	modport rx (
		output cmd_valid,
		output frame_done,
		output cs_rise,
		output cmd,
		output data,
		input rd_word
	);

	modport core (
		input cmd_valid,
		input frame_done,
		input cs_rise,
		input cmd,
		input data,
		output rd_word
	);
endinterface

// File: design/dtf_spi_rx.sv
`timescale 1ns/1ns
module dtf_spi_rx
	import dtf_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic frame_select_load,
	input wire logic sdi,
	output logic sdo,
	dtf_frame_if.rx fi
);

	logic [2:0] pin_s1;
	logic [2:0] pin_s2;
	logic sclk_prev;
	logic cs_prev;
	logic [5:0] bit_cnt;
	logic [31:0] sh_in;
	logic [23:0] sh_out;
	logic load_out;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_high;

	// ------------------------------------------------------------
	// pin synchronisers and edge finding
	// ------------------------------------------------------------
	// two stages; only the second stage feeds logic
	always_ff @(posedge clk) begin
		pin_s1 <= {sclk, frame_select_load, sdi};
		pin_s2 <= pin_s1;
		sclk_prev <= pin_s2[2];
		cs_prev <= pin_s2[1];
	end

	assign sclk_rise = pin_s2[2] & ~sclk_prev;
	assign sclk_fall = ~pin_s2[2] & sclk_prev;
	assign cs_high = pin_s2[1];

	// ------------------------------------------------------------
	// shift in, msb first on rising sclk
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (sys_rst || cs_high) begin
			bit_cnt <= '0;
		end else if (sclk_rise && bit_cnt <= 6'(DTF_FRAME_BITS)) begin
			bit_cnt <= bit_cnt + 6'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sh_in <= '0;
		end else if (sclk_rise && !cs_high) begin
			sh_in <= {sh_in[30:0], pin_s2[0]};
		end
	end

	// command byte complete on the eighth rising edge
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fi.cmd_valid <= 1'b0;
			fi.cmd <= '0;
		end else begin
			fi.cmd_valid <= sclk_rise && !cs_high &&
				bit_cnt == 6'(DTF_CMD_BITS - 1);
			if (sclk_rise && !cs_high &&
				bit_cnt == 6'(DTF_CMD_BITS - 1)) begin
				fi.cmd <= {sh_in[6:0], pin_s2[0]};
			end
		end
	end

	// a short or long frame is dropped: only exactly 32 bits execute
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fi.frame_done <= 1'b0;
			fi.cs_rise <= 1'b0;
			fi.data <= '0;
		end else begin
			fi.cs_rise <= cs_high & ~cs_prev;
			fi.frame_done <= cs_high && !cs_prev &&
				bit_cnt == 6'(DTF_FRAME_BITS);
			fi.data <= sh_in[DTF_DATA_LSB +: DTF_CODE_W];
		end
	end

	// ------------------------------------------------------------
	// readback, changes on falling sclk
	// ------------------------------------------------------------
	// rd_word is decoded from cmd in the cmd_valid cycle and loaded one cycle after cmd_valid
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			load_out <= 1'b0;
			sh_out <= '0;
			sdo <= 1'b0;
		end else begin
			load_out <= fi.cmd_valid;
			if (cs_high) begin
				sdo <= 1'b0;
			end else if (load_out) begin
				sh_out <= {fi.rd_word, 8'h00};
			end else if (sclk_fall && bit_cnt >= 6'(DTF_CMD_BITS)) begin
				sdo <= sh_out[23];
				sh_out <= {sh_out[22:0], 1'b0};
			end
		end
	end

endmodule

// File: design/dtf_top.sv
`timescale 1ns/1ns
module dtf_top
	import dtf_pkg::*;
#(
	parameter int NCHAN = DTF_NCHAN
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic sclk,
	input wire logic frame_select_load,
	input wire logic sdi,
	input wire logic clear_input_pin_n,
	input wire logic [NCHAN-1:0] overtemp_trip,
	input wire logic [NCHAN-1:0] overtemp_warm,
	output logic sdo,
	output logic alarm_out,
	output logic alarm_oe_n,
	output logic [NCHAN-1:0] chan_power_down,
	output logic chip_power_down,
	output logic overtemp_protect_off,
	output logic [NCHAN-1:0] toggle_mode,
	output logic wr_valid,
	output logic wr_kind,
	output logic [3:0] wr_chan,
	output logic [15:0] wr_data
);

	dtf_frame_if fi();

	logic [NCHAN-1:0] trip_s1;
	logic [NCHAN-1:0] trip_s2;
	logic [NCHAN-1:0] warm_s1;
	logic [NCHAN-1:0] warm_s2;
	logic clr_s1;
	logic clr_s2;
	logic soft_rst;
	logic init;
	logic all_cool;
	logic [NCHAN-1:0] trip_evt;
	logic any_trip;
	logic [NCHAN-1:0] new_trip;
	logic any_new_trip;
	logic [NCHAN-1:0] channel_overtemp_status;
	logic [NCHAN-1:0] pd_reg;
	logic overtemp_fault_flag;
	logic [1:0] cfg_misc;
	logic [DTF_CODE_W-1:0] channel_code_bits [NCHAN];
	logic [DTF_SET_W-1:0] chan_set [NCHAN];
	logic [3:0] cmd_chan;
	logic wr_code_hit;
	logic wr_set_hit;
	logic wr_cfg_hit;
	logic wr_pd_hit;
	logic wr_flt_hit;

	// ------------------------------------------------------------
	// serial frame receiver
	// ------------------------------------------------------------
	dtf_spi_rx u_rx (
		.clk(clk),
		.sys_rst(sys_rst),
		.sclk(sclk),
		.frame_select_load(frame_select_load),
		.sdi(sdi),
		.sdo(sdo),
		.fi(fi)
	);

	// ------------------------------------------------------------
	// command decode
	// ------------------------------------------------------------
	// exact whole-byte match, used by both the write and the read decode
	function automatic logic cmd_is(input logic [7:0] c,
		input logic [7:0] code);
		cmd_is = (c == code);
	endfunction

	// nibble-addressed commands carry the channel in the low nibble
	function automatic logic nib_is(input logic [7:0] c,
		input logic [3:0] nib);
		nib_is = (c[7:4] == nib);
	endfunction

	// reads decode from the command byte alone, so the receiver can load
	// the answer well before the first data bit is shifted out
	assign cmd_chan = fi.cmd[3:0];
	assign wr_code_hit = fi.frame_done &&
		nib_is(fi.cmd, DTF_NIB_WR_CODE);
	assign wr_set_hit = fi.frame_done &&
		nib_is(fi.cmd, DTF_NIB_WR_SET);
	assign wr_cfg_hit = fi.frame_done && cmd_is(fi.cmd, DTF_CMD_WR_CFG);
	assign wr_pd_hit = fi.frame_done && cmd_is(fi.cmd, DTF_CMD_WR_PD);
	assign wr_flt_hit = fi.frame_done && cmd_is(fi.cmd, DTF_CMD_WR_FAULT);

	// ------------------------------------------------------------
	// detector and clear pin synchronisers
	// ------------------------------------------------------------
	// detectors are analog and asynchronous to clk
	always_ff @(posedge clk) begin
		trip_s1 <= overtemp_trip;
		trip_s2 <= trip_s1;
		// warm detectors only gate recovery, so no edge finding
		warm_s1 <= overtemp_warm;
		warm_s2 <= warm_s1;
		clr_s1 <= clear_input_pin_n;
		clr_s2 <= clr_s1;
	end

	// ------------------------------------------------------------
	// reset sources
	// ------------------------------------------------------------
	// soft reset self clears: one cycle after the config write
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			soft_rst <= 1'b0;
		end else begin
			soft_rst <= wr_cfg_hit && fi.data[DTF_CFG_RST_BIT];
		end
	end

	// clear pin held low acts as a level reset of the register state;
	// limitation: it and soft reset release latched channels without
	// looking at the warm detectors, a still hot channel trips again
	assign init = sys_rst | soft_rst | ~clr_s2;

	// ------------------------------------------------------------
	// thermal events
	// ------------------------------------------------------------
	// every detector below the recovery point before release
	assign all_cool = ~|warm_s2;

	// one trip term per channel; the disable bit masks them all
	genvar gi;
	generate
		for (gi = 0; gi < NCHAN; gi++) begin : g_trip
			assign trip_evt[gi] = trip_s2[gi] &
				~overtemp_protect_off;
			// only a channel not yet latched counts as a fresh trip
			assign new_trip[gi] = trip_evt[gi] &
				~channel_overtemp_status[gi];
		end
	endgenerate

	// level keeps the fault flag up; the fresh-trip pulse drives the
	// alarm so a frame end can release it while the die is still hot
	assign any_trip = |trip_evt;
	assign any_new_trip = |new_trip;

	// ------------------------------------------------------------
	// thermal status and power-down registers
	// ------------------------------------------------------------
	// a trip beats any pd write in the same cycle; a cleared bit only
	// releases a latched channel when all detectors read cool and the
	// fault flag is already clear, so one stray write cannot undo a
	// shutdown the host has not yet seen
	always_ff @(posedge clk) begin
		if (init) begin
			channel_overtemp_status <= '0;
			pd_reg <= DTF_PD_RST;
		end else begin
			for (int i = 0; i < NCHAN; i++) begin
				if (trip_evt[i]) begin
					channel_overtemp_status[i] <= 1'b1;
					pd_reg[i] <= 1'b1;
				end else if (wr_pd_hit) begin
					if (!channel_overtemp_status[i]) begin
						pd_reg[i] <= fi.data[i];
					end else if (all_cool && !fi.data[i] &&
						!overtemp_fault_flag) begin
						pd_reg[i] <= 1'b0;
						channel_overtemp_status[i] <= 1'b0;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// fault flag
	// ------------------------------------------------------------
	// sticky; host write may clear, a trip in that cycle wins; the trip
	// term is a level, so with protection on a clear while a detector is still hot never
	// takes effect
	always_ff @(posedge clk) begin
		if (init) begin
			overtemp_fault_flag <= 1'b0;
		end else if (any_trip) begin
			overtemp_fault_flag <= 1'b1;
		end else if (wr_flt_hit) begin
			overtemp_fault_flag <= fi.data[DTF_FLT_TSF_BIT];
		end
	end

	// ------------------------------------------------------------
	// alarm pin, open drain
	// ------------------------------------------------------------
	// level is always low; the enable decides pull-down or release
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alarm_out <= 1'b0;
		end else begin
			alarm_out <= 1'b0;
		end
	end

	// release on frame end regardless of temperature; a fresh trip in
	// the same cycle keeps the pin pulled low. a channel that stays hot
	// after release does not pull again: only a channel that newly
	// latches does, so the host is not locked out of the alarm
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			alarm_oe_n <= 1'b1;
		end else if (any_new_trip) begin
			alarm_oe_n <= 1'b0;
		end else if (fi.cs_rise) begin
			alarm_oe_n <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// configuration register
	// ------------------------------------------------------------
	// the reset bit is not stored: it only fires soft_rst and reads 0
	always_ff @(posedge clk) begin
		if (init) begin
			overtemp_protect_off <= 1'b0;
			cfg_misc <= 2'b00;
		end else if (wr_cfg_hit) begin
			overtemp_protect_off <= fi.data[DTF_CFG_TSDOFF_BIT];
			cfg_misc <= fi.data[DTF_CFG_MISC_LSB +: 2];
		end
	end

	// ------------------------------------------------------------
	// channel codes and settings
	// ------------------------------------------------------------
	// per-channel storage; clear pin and soft reset zero it too
	always_ff @(posedge clk) begin
		if (init) begin
			for (int i = 0; i < NCHAN; i++) begin
				channel_code_bits[i] <= DTF_CODE_RST;
				chan_set[i] <= DTF_SET_RST;
			end
		end else begin
			if (wr_code_hit) begin
				channel_code_bits[cmd_chan] <= fi.data;
			end
			if (wr_set_hit) begin
				// mode, dither phase, dither period, toggle source
				chan_set[cmd_chan] <=
					fi.data[DTF_SET_LSB +: DTF_SET_W];
			end
		end
	end

	// ------------------------------------------------------------
	// write notification to the converter side
	// ------------------------------------------------------------
	// kind 0 is a code, kind 1 a settings byte in data[11:4]
	// fields stay standing between pulses for a slow consumer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_valid <= 1'b0;
			wr_kind <= 1'b0;
			wr_chan <= '0;
			wr_data <= '0;
		end else begin
			wr_valid <= wr_code_hit | wr_set_hit;
			if (wr_code_hit | wr_set_hit) begin
				wr_kind <= wr_set_hit;
				wr_chan <= cmd_chan;
				wr_data <= fi.data;
			end
		end
	end

	// ------------------------------------------------------------
	// channel and chip power state
	// ------------------------------------------------------------
	// a fully tripped die also shuts reference and bias down
	// chip bit follows status, not pd, so a pd write cannot fake it
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			chan_power_down <= '0;
			chip_power_down <= 1'b0;
			toggle_mode <= '0;
		end else begin
			chan_power_down <= pd_reg;
			chip_power_down <= &channel_overtemp_status;
			for (int i = 0; i < NCHAN; i++) begin
				toggle_mode[i] <= chan_set[i][DTF_SET_W-1];
			end
		end
	end

	// ------------------------------------------------------------
	// readback word, same layout as the matching write
	// ------------------------------------------------------------
	// unknown read codes return zero
	// the receiver loads this one cycle after the command byte lands
	always_comb begin
		fi.rd_word = '0;
		if (nib_is(fi.cmd, DTF_NIB_RD_CODE)) begin
			fi.rd_word = channel_code_bits[cmd_chan];
		end else if (nib_is(fi.cmd, DTF_NIB_RD_SET)) begin
			fi.rd_word[DTF_SET_LSB +: DTF_SET_W] =
				chan_set[cmd_chan];
		end else if (cmd_is(fi.cmd, DTF_CMD_RD_CFG)) begin
			fi.rd_word[DTF_CFG_TSDOFF_BIT] = overtemp_protect_off;
			fi.rd_word[DTF_CFG_MISC_LSB +: 2] = cfg_misc;
		end else if (cmd_is(fi.cmd, DTF_CMD_RD_PD)) begin
			fi.rd_word = pd_reg;
		end else if (cmd_is(fi.cmd, DTF_CMD_RD_FAULT)) begin
			fi.rd_word[DTF_FLT_TSF_BIT] = overtemp_fault_flag;
		end else if (cmd_is(fi.cmd, DTF_CMD_RD_TSD)) begin
			// channel 15 leaves first, msb first shift
			fi.rd_word = channel_overtemp_status;
		end
	end

endmodule

// File: test/dtf_top_props.sv
`timescale 1ns/1ns
module dtf_top_props
	import dtf_pkg::*;
#(
	parameter int NCHAN = DTF_NCHAN
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic frame_select_load,
	input wire logic clear_input_pin_n,
	input wire logic [NCHAN-1:0] overtemp_trip,
	input wire logic [NCHAN-1:0] overtemp_warm,
	input wire logic sdo,
	input wire logic alarm_out,
	input wire logic alarm_oe_n,
	input wire logic [NCHAN-1:0] chan_power_down,
	input wire logic chip_power_down,
	input wire logic overtemp_protect_off,
	input wire logic wr_valid,
	input wire logic wr_kind,
	input wire logic [3:0] wr_chan,
	input wire logic [15:0] wr_data
);
	// ------------
	// port checks
	// ------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// frame end, detectors quiet long enough to clear the synchroniser
	sequence cool_frame_end;
		(overtemp_trip == '0)[*3] ##0 !frame_select_load
		##1 (frame_select_load && overtemp_trip == '0)[*5];
	endsequence
	// steady trip with protection on and clear pin idle
	sequence hot_hold;
		(!overtemp_protect_off && clear_input_pin_n && overtemp_trip != '0
		&& $stable(overtemp_trip))[*7];
	endsequence

	AST_ALARM_OUT_LOW: assert property (alarm_out == 1'b0)
		else $error("alarm level not low");
	AST_TRIP_SETS: assert property (hot_hold |->
		(chan_power_down & overtemp_trip) != '0)
		else $error("trip did not power down channel");
	AST_ALARM_RELEASE: assert property (cool_frame_end |-> alarm_oe_n)
		else $error("alarm held after frame end");
	AST_PROTECT_QUIET: assert property (
		overtemp_protect_off[*4] |-> alarm_oe_n)
		else $error("alarm with protection off");
	AST_CHIP_PD: assert property (chip_power_down |-> &chan_power_down)
		else $error("chip down with a channel up");
	AST_PD_LATCH: assert property (
		(overtemp_warm != '0 && clear_input_pin_n)[*5] |->
		($past(chan_power_down) & ~chan_power_down) == '0)
		else $error("channel restored while warm");
	AST_WR_PULSE: assert property (wr_valid |=> !wr_valid)
		else $error("write pulse too long");
	AST_WR_HOLD: assert property (
		(!wr_valid && clear_input_pin_n)[*4] |->
		$stable({wr_kind, wr_chan, wr_data}))
		else $error("write fields moved without write");
	AST_SDO_IDLE: assert property (frame_select_load[*4] |-> !sdo)
		else $error("sdo driven outside frame");
endmodule

bind dtf_top dtf_top_props #(.NCHAN(NCHAN)) dtf_top_props_inst (
	.clk(clk),
	.sys_rst(sys_rst),
	.frame_select_load(frame_select_load),
	.clear_input_pin_n(clear_input_pin_n),
	.overtemp_trip(overtemp_trip),
	.overtemp_warm(overtemp_warm),
	.sdo(sdo),
	.alarm_out(alarm_out),
	.alarm_oe_n(alarm_oe_n),
	.chan_power_down(chan_power_down),
	.chip_power_down(chip_power_down),
	.overtemp_protect_off(overtemp_protect_off),
	.wr_valid(wr_valid),
	.wr_kind(wr_kind),
	.wr_chan(wr_chan),
	.wr_data(wr_data)
);

// File: test/dtf_host.sv
`timescale 1ns/1ns
// ------------
// serial host
// ------------
module dtf_host (
	input wire logic clk,
	input wire logic sdo,
	output logic sclk,
	output logic frame_select_load,
	output logic sdi
);
	// link idles with clock low and select high
	initial begin
		sclk = 1'b0;
		frame_select_load = 1'b1;
		sdi = 1'b0;
	end
	// one 32-bit frame, mode 0, msb first; read word taken on sclk rise
	task automatic xfer(input logic [31:0] f, output logic [15:0] rd);
		rd = '0;
		@(posedge clk);
		#1 frame_select_load = 1'b0;
		for (int i = 0; i < 32; i++) begin
			sdi = f[31-i];
			#40 sclk = 1'b1;
			if (i >= 8 && i < 24) begin
				rd[23-i] = sdo;
			end
			#40 sclk = 1'b0;
		end
		#40 frame_select_load = 1'b1;
		// released line shows the inverse, never a stale bit
		sdi = ~sdi;
		repeat (10) @(posedge clk);
		#1;
	endtask
endmodule

// File: test/dtf_top_tb.sv
`timescale 1ns/1ns
module dtf_top_tb;
	import dtf_pkg::*;
	logic clk, sys_rst, sclk, frame_select_load, sdi, clear_input_pin_n;
	logic [15:0] overtemp_trip, overtemp_warm, chan_power_down, toggle_mode;
	logic [15:0] wr_data, rdw;
	logic [3:0] wr_chan;
	logic sdo, alarm_out, alarm_oe_n, chip_power_down, overtemp_protect_off;
	logic wr_valid, wr_kind;
	int errors, checks_done, wr_seen;

	// ------------
	// harness
	// ------------
	dtf_top #(.NCHAN(DTF_NCHAN)) dtf_top_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.sclk(sclk),
		.frame_select_load(frame_select_load),
		.sdi(sdi),
		.clear_input_pin_n(clear_input_pin_n),
		.overtemp_trip(overtemp_trip),
		.overtemp_warm(overtemp_warm),
		.sdo(sdo),
		.alarm_out(alarm_out),
		.alarm_oe_n(alarm_oe_n),
		.chan_power_down(chan_power_down),
		.chip_power_down(chip_power_down),
		.overtemp_protect_off(overtemp_protect_off),
		.toggle_mode(toggle_mode),
		.wr_valid(wr_valid),
		.wr_kind(wr_kind),
		.wr_chan(wr_chan),
		.wr_data(wr_data)
	);
	dtf_host dtf_host_inst (
		.clk(clk),
		.sdo(sdo),
		.sclk(sclk),
		.frame_select_load(frame_select_load),
		.sdi(sdi)
	);
	// 250 MHz system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// counts write pulses, so a lost or stretched pulse shows
	always @(posedge clk) begin
		if (wr_valid === 1'b1) begin
			wr_seen <= wr_seen + 1;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [31:0] f);
		logic [15:0] d;
		dtf_host_inst.xfer(f, d);
	endtask
	task automatic rd(input logic [7:0] c);
		dtf_host_inst.xfer({c, 24'h00_0000}, rdw);
	endtask

	task automatic t_reset();
		chk(alarm_oe_n, 1'b1, "alarm idle");
		chk(chip_power_down, 1'b0, "chip idle");
		chk(overtemp_protect_off, 1'b0, "protect reset");
		chk(alarm_out, 1'b0, "alarm level");
		chk(toggle_mode, 16'h0000, "mode reset");
		rd(8'hF7);
		chk(rdw, 16'h0000, "status reset");
		rd(8'h83);
		chk(rdw, DTF_CODE_RST, "code reset");
		rd(8'h95);
		chk(rdw, 16'h0000, "settings reset");
		$display("reset test done");
	endtask
	task automatic t_code();
		int n;
		n = wr_seen;
		wr(32'h0312_3400);
		chk(wr_seen, n + 1, "one write pulse");
		chk({wr_kind, wr_chan, wr_data}, 21'h03_1234, "code write");
		rd(8'h83);
		chk(rdw, 16'h1234, "code readback");
		rd(8'h84);
		chk(rdw, 16'h0000, "neighbour code");
		$display("code test done");
	endtask
	// every toggle source, both modes, several phases and periods
	task automatic t_settings();
		logic [7:0] s;
		for (int i = 0; i < 4; i++) begin
			s = {i[0], i[1:0], 3'(i + 3), i[1:0]};
			wr({8'h15, 4'h0, s, 12'h000});
			chk({wr_kind, wr_chan}, 5'h15, "settings target");
			chk(toggle_mode, {10'h000, i[0], 5'h00}, "mode");
			rd(8'h95);
			chk(rdw, {4'h0, s, 4'h0}, "settings read");
		end
		$display("settings test done");
	endtask
	task automatic t_trip();
		overtemp_warm = 16'h0004;
		overtemp_trip = 16'h0004;
		tick(8);
		chk(alarm_oe_n, 1'b0, "alarm low");
		chk(chan_power_down, 16'h0004, "one down");
		chk(chip_power_down, 1'b0, "chip up");
		// still hot: the frame end must release the alarm all the same
		rd(8'hF7);
		chk(rdw, 16'h0004, "status bit");
		chk(alarm_oe_n, 1'b1, "released hot");
		overtemp_trip = 16'h0000;
		tick(4);
		rd(8'hF1);
		chk(rdw, 16'h0004, "pd bit");
		rd(8'hF6);
		chk(rdw, 16'h0004, "fault flag");
		chk(alarm_oe_n, 1'b1, "alarm released");
		// still warm, so the clears must not restore
		wr(32'h7600_0000);
		wr(32'h7100_0000);
		chk(chan_power_down, 16'h0004, "latched warm");
		overtemp_warm = 16'h0000;
		wr(32'h7600_0000);
		wr(32'h7100_0000);
		rd(8'hF7);
		chk(rdw, 16'h0000, "status clear");
		chk(chan_power_down, 16'h0000, "restored");
		$display("trip test done");
	endtask
	task automatic t_all();
		overtemp_trip = 16'hFFFF;
		tick(8);
		chk({chip_power_down, chan_power_down}, 17'h1_FFFF, "all");
		overtemp_trip = 16'h0000;
		tick(4);
		wr(32'h7080_0000);
		chk({chip_power_down, chan_power_down}, 17'h0_0000, "soft");
		rd(8'hF6);
		chk(rdw, 16'h0000, "fault soft");
		overtemp_trip = 16'h0200;
		tick(8);
		overtemp_trip = 16'h0000;
		clear_input_pin_n = 1'b0;
		tick(6);
		clear_input_pin_n = 1'b1;
		tick(4);
		chk(chan_power_down, 16'h0000, "clear pin");
		rd(8'hF6);
		chk(rdw, 16'h0000, "fault clear pin");
		$display("shutdown test done");
	endtask
	task automatic t_off();
		wr(32'h7000_0400);
		chk(overtemp_protect_off, 1'b1, "protect off");
		rd(8'hF0);
		chk(rdw, 16'h0004, "config read");
		overtemp_trip = 16'h0080;
		tick(8);
		chk({alarm_oe_n, chan_power_down}, 17'h1_0000, "no trip");
		overtemp_trip = 16'h0000;
		tick(4);
		wr(32'h7000_0000);
		chk(overtemp_protect_off, 1'b0, "protect on");
		$display("protect test done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// hang guard, about twice the expected run of some 19k cycles
	initial begin
		#160000;
		errors++;
		$display("BAD %0t watchdog expired", $time);
		report_and_stop();
	end
	// reset, then the scenarios in turn
	initial begin
		sys_rst = 1'b1;
		clear_input_pin_n = 1'b1;
		overtemp_trip = 16'h0000;
		overtemp_warm = 16'h0000;
		repeat (12) @(posedge clk);
		#1 sys_rst = 1'b0;
		tick(4);
		t_reset();
		t_code();
		t_settings();
		t_trip();
		t_all();
		t_off();
		report_and_stop();
	end
endmodule
